// *** src/autoneg_gigabit_ctrl_regs.sv ***
// management register bank for negotiation advertisement, partner pages and gigabit control
// Function
// RQ1: advertisement bit 15 requests next page exchange, writable, resets zero.
// RQ2: advertisement bits 11,10 pause abilities, bit 13 remote fault, all reset zero.
// RQ3: advertisement bits 9..5 abilities reset 01111, selector resets 00001.
// RQ4: partner base page register read-only, mirrors received base page, resets zero.
// RQ5: expansion bit 4 parallel detection fault latches high until read.
// RQ6: expansion bit 1 new page received, latching, resets zero.
// RQ7: expansion bit 2 reads one, bit 3 partner np, bit 0 partner negotiates.
// RQ8: next page transmit bit 15 more pages, code field 10:0 resets to one.
// RQ9: next page transmit bit 13 message page, bit 12 comply, both writable.
// RQ10: next page transmit bit 11 read-only toggle, inverse of previous codeword toggle.
// RQ11: partner next page register read-only, latest next page, resets zero.
// RQ12: gigabit control bits 15:13 select transmitter test mode, 101..111 reserved.
// RQ13: software disables media sensing before any non-normal test mode.
// RQ14: bit 12 enables manual master/slave; value bit only acts while enabled.
// RQ15: with manual enabled, bit 11 one means master, zero slave, resets zero.
// RQ16: bits 9,8 advertise gigabit full/half, bit 10 multi-port, all reset one.
// RQ17: software sets master/slave bit 11 before forcing gigabit speed.
// RQ18: latched bits clear on the read returning them; concurrent events survive.
// RQ19: writes to read-only fields ignored; reserved read-only bits read reset values.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module autoneg_gigabit_ctrl_regs
	import an_regs_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire mgmt_req_type mgmt_req,
	output logic [15:0] rdata,
	input wire link_event_type link_event,
	output neg_ctrl_type neg_ctrl,
	output logic irq
);

	typedef struct packed {
		logic [15:0] advert;
		logic [15:0] partner_base;
		logic par_fault;
		logic page_rx;
		logic partner_np_able;
		logic partner_an_able;
		logic [15:0] np_tx;
		logic [15:0] np_rx;
		logic [15:0] gig_ctrl;
		logic np_tx_pending;
		np_state_type np_state;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic [15:0] rdata;
		logic irq;
		neg_ctrl_type ctrl;
	} state_type;

	state_type state_r;
	state_type state_nxt;
	logic [15:0] read_mux;
	logic [15:0] expansion_view;
	logic [2:0] irq_events;

	always_comb begin
		expansion_view = 16'h0000; // [RQ7]
		expansion_view[EXP_PAR_FAULT_BIT] = state_r.par_fault; // [RQ5]
		expansion_view[EXP_PARTNER_NP_BIT] = state_r.partner_np_able; // [RQ7]
		expansion_view[EXP_LOCAL_NP_BIT] = 1'b1; // [RQ7]
		expansion_view[EXP_PAGE_RX_BIT] = state_r.page_rx; // [RQ6]
		expansion_view[EXP_PARTNER_AN_BIT] = state_r.partner_an_able; // [RQ7]
		read_mux = 16'h0000;
		if (mgmt_req.addr == OFS_ADVERT) begin
			read_mux = state_r.advert;
		end else if (mgmt_req.addr == OFS_PARTNER_BASE) begin
			read_mux = state_r.partner_base; // [RQ4]
		end else if (mgmt_req.addr == OFS_EXPANSION) begin
			read_mux = expansion_view;
		end else if (mgmt_req.addr == OFS_NP_TX) begin
			read_mux = state_r.np_tx;
		end else if (mgmt_req.addr == OFS_NP_RX) begin
			read_mux = state_r.np_rx; // [RQ11]
		end else if (mgmt_req.addr == OFS_GIG_CTRL) begin
			read_mux = state_r.gig_ctrl;
		end else if (mgmt_req.addr == OFS_IRQ_STATUS) begin
			read_mux = {13'h0000, state_r.irq_status};
		end else if (mgmt_req.addr == OFS_IRQ_MASK) begin
			read_mux = {13'h0000, state_r.irq_mask};
		end
	end

	always_comb begin
		irq_events = 3'h0;
		irq_events[IRQ_PAGE_RX_BIT] = link_event.next_page_valid | link_event.base_page_valid;
		irq_events[IRQ_PAR_FAULT_BIT] = link_event.parallel_fault;
		irq_events[IRQ_BASE_PAGE_BIT] = link_event.base_page_valid;
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.rdata = 16'h0000;
		if (mgmt_req.rd) begin
			state_nxt.rdata = read_mux;
		end
		// writes: only writable bits change [RQ19]
		if (mgmt_req.wr) begin
			if (mgmt_req.addr == OFS_ADVERT) begin
				state_nxt.advert = (state_r.advert & ~ADVERT_WMASK) | (mgmt_req.wdata & ADVERT_WMASK); // [RQ1] [RQ2] [RQ3]
			end else if (mgmt_req.addr == OFS_NP_TX) begin
				state_nxt.np_tx = (state_r.np_tx & ~NP_TX_WMASK) | (mgmt_req.wdata & NP_TX_WMASK); // [RQ8] [RQ9]
				state_nxt.np_tx_pending = 1'b1;
			end else if (mgmt_req.addr == OFS_GIG_CTRL) begin
				state_nxt.gig_ctrl = mgmt_req.wdata & GIG_CTRL_WMASK; // [RQ12] [RQ16]
			end else if (mgmt_req.addr == OFS_IRQ_MASK) begin
				state_nxt.irq_mask = mgmt_req.wdata[2:0];
			end
		end
		// read clears latched bits, events in same cycle win [RQ18]
		if (mgmt_req.rd && mgmt_req.addr == OFS_EXPANSION) begin
			state_nxt.par_fault = 1'b0; // [RQ5]
			state_nxt.page_rx = 1'b0; // [RQ6]
		end
		if (mgmt_req.rd && mgmt_req.addr == OFS_IRQ_STATUS) begin
			state_nxt.irq_status = IRQ_RESET;
		end
		if (link_event.parallel_fault) begin
			state_nxt.par_fault = 1'b1; // [RQ5] [RQ18]
		end
		if (link_event.base_page_valid) begin
			state_nxt.partner_base = link_event.base_page; // [RQ4]
			state_nxt.page_rx = 1'b1; // [RQ6] [RQ18]
		end
		if (link_event.next_page_valid) begin
			state_nxt.np_rx = link_event.next_page; // [RQ11]
			state_nxt.page_rx = 1'b1; // [RQ6]
		end
		state_nxt.partner_np_able = link_event.partner_np_able; // [RQ7]
		state_nxt.partner_an_able = link_event.partner_an_able; // [RQ7]
		state_nxt.irq_status = state_nxt.irq_status | irq_events;
		// next page handshake with negotiation engine
		case (state_r.np_state)
			NP_IDLE: begin
				if (link_event.codeword_sent) begin
					state_nxt.np_state = NP_SENT;
				end
			end
			NP_SENT: begin
				state_nxt.np_state = NP_IDLE;
			end
			default: begin
				state_nxt.np_state = NP_IDLE;
			end
		endcase
		if (link_event.codeword_sent) begin
			state_nxt.np_tx[NP_TX_TOGGLE_BIT] = ~link_event.codeword_toggle; // [RQ10]
			state_nxt.np_tx_pending = 1'b0;
		end
		state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);
		state_nxt.ctrl.test_mode = test_mode_type'(state_nxt.gig_ctrl[GIG_TEST_LSB +: 3]); // [RQ12]
		state_nxt.ctrl.ms_manual = state_nxt.gig_ctrl[GIG_MS_MANUAL_BIT]; // [RQ14]
		state_nxt.ctrl.ms_master = state_nxt.gig_ctrl[GIG_MS_MANUAL_BIT] & state_nxt.gig_ctrl[GIG_MS_VALUE_BIT]; // [RQ14] [RQ15]
		state_nxt.ctrl.multi_port = state_nxt.gig_ctrl[GIG_MULTI_PORT_BIT]; // [RQ16]
		state_nxt.ctrl.adv_1000_full_duplex = state_nxt.gig_ctrl[GIG_ADV_FULL_DUPLEX_BIT]; // [RQ16]
		state_nxt.ctrl.adv_1000_half_duplex = state_nxt.gig_ctrl[GIG_ADV_HALF_DUPLEX_BIT]; // [RQ16]
		state_nxt.ctrl.next_page_request = state_nxt.advert[ADV_NEXT_PAGE_BIT]; // [RQ1]
		state_nxt.ctrl.advert = state_nxt.advert;
		state_nxt.ctrl.np_tx = state_nxt.np_tx;
		state_nxt.ctrl.np_tx_pending = state_nxt.np_tx_pending;
		if (reset) begin
			state_nxt = '0;
			state_nxt.advert = ADVERT_RESET; // [RQ1] [RQ2] [RQ3]
			state_nxt.np_tx = NP_TX_RESET; // [RQ8] [RQ9]
			state_nxt.gig_ctrl = GIG_CTRL_RESET; // [RQ14] [RQ15] [RQ16]
			state_nxt.np_state = NP_IDLE;
			state_nxt.irq_status = IRQ_RESET;
			state_nxt.ctrl.test_mode = TEST_NORMAL;
			state_nxt.ctrl.multi_port = 1'b1;
			state_nxt.ctrl.adv_1000_full_duplex = 1'b1;
			state_nxt.ctrl.adv_1000_half_duplex = 1'b1;
			state_nxt.ctrl.advert = ADVERT_RESET;
			state_nxt.ctrl.np_tx = NP_TX_RESET;
		end
	end

	always_ff @(posedge clk) begin
		state_r <= state_nxt;
	end

	assign rdata = state_r.rdata;
	assign neg_ctrl = state_r.ctrl;
	assign irq = state_r.irq;

	property p_advert_reset;
		@(posedge clk) $fell(reset) |-> state_r.advert == ADVERT_RESET;
	endproperty
	a_advert_reset: assert property (p_advert_reset) else $error("advertisement reset value wrong"); // [RQ3]

	property p_next_page_req;
		@(posedge clk) disable iff (reset)
		mgmt_req.wr && mgmt_req.addr == OFS_ADVERT
		|=> neg_ctrl.next_page_request == $past(mgmt_req.wdata[ADV_NEXT_PAGE_BIT]);
	endproperty
	a_next_page_req: assert property (p_next_page_req) else $error("next page request not taken"); // [RQ1]

	property p_par_fault_latch;
		@(posedge clk) disable iff (reset)
		link_event.parallel_fault |=> state_r.par_fault;
	endproperty
	a_par_fault_latch: assert property (p_par_fault_latch) else $error("parallel fault lost"); // [RQ5]

	property p_page_rx_clear;
		@(posedge clk) disable iff (reset)
		mgmt_req.rd && mgmt_req.addr == OFS_EXPANSION && !link_event.base_page_valid && !link_event.next_page_valid
		|=> !state_r.page_rx;
	endproperty
	a_page_rx_clear: assert property (p_page_rx_clear) else $error("page received not cleared on read"); // [RQ18]

	property p_local_np;
		@(posedge clk) disable iff (reset)
		mgmt_req.rd && mgmt_req.addr == OFS_EXPANSION |=> rdata[EXP_LOCAL_NP_BIT] && rdata[15:5] == 11'h000;
	endproperty
	a_local_np: assert property (p_local_np) else $error("expansion constant bits wrong"); // [RQ7]

	property p_toggle;
		@(posedge clk) disable iff (reset)
		link_event.codeword_sent |=> state_r.np_tx[NP_TX_TOGGLE_BIT] == !$past(link_event.codeword_toggle);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle bit not inverted"); // [RQ10]

	property p_ro_ignored;
		@(posedge clk) disable iff (reset)
		mgmt_req.wr && mgmt_req.addr == OFS_NP_RX && !link_event.next_page_valid |=> $stable(state_r.np_rx);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only register written"); // [RQ19]

	property p_ms_gate;
		@(posedge clk) disable iff (reset)
		!state_r.gig_ctrl[GIG_MS_MANUAL_BIT] |-> !neg_ctrl.ms_master;
	endproperty
	a_ms_gate: assert property (p_ms_gate) else $error("master value acts without manual enable"); // [RQ14]

	property p_base_capture;
		@(posedge clk) disable iff (reset)
		link_event.base_page_valid |=> state_r.partner_base == $past(link_event.base_page);
	endproperty
	a_base_capture: assert property (p_base_capture) else $error("partner base page not captured"); // [RQ4]

	property p_gig_reset;
		@(posedge clk) $fell(reset) |-> neg_ctrl.test_mode == TEST_NORMAL && neg_ctrl.multi_port && !neg_ctrl.ms_master;
	endproperty
	a_gig_reset: assert property (p_gig_reset) else $error("gigabit control reset wrong"); // [RQ16]

	property p_np_tx_reset;
		@(posedge clk) $fell(reset) |-> state_r.np_tx == NP_TX_RESET;
	endproperty
	a_np_tx_reset: assert property (p_np_tx_reset) else $error("next page transmit reset value wrong"); // [RQ8]

	property p_gig_ctrl_reset;
		@(posedge clk) $fell(reset) |-> state_r.gig_ctrl == GIG_CTRL_RESET;
	endproperty
	a_gig_ctrl_reset: assert property (p_gig_ctrl_reset) else $error("gigabit register reset value wrong"); // [RQ16]

	property p_partner_reset;
		@(posedge clk) $fell(reset) |-> state_r.partner_base == 16'h0000;
	endproperty
	a_partner_reset: assert property (p_partner_reset) else $error("partner base page not zero after reset"); // [RQ4]

	property p_latch_reset;
		@(posedge clk) $fell(reset) |-> !state_r.page_rx && !state_r.par_fault;
	endproperty
	a_latch_reset: assert property (p_latch_reset) else $error("latched expansion bits set after reset"); // [RQ6]

	property p_np_rx_reset;
		@(posedge clk) $fell(reset) |-> state_r.np_rx == 16'h0000;
	endproperty
	a_np_rx_reset: assert property (p_np_rx_reset) else $error("partner next page not zero after reset"); // [RQ11]

	property p_advert_ro_bits;
		@(posedge clk) disable iff (reset)
		(state_r.advert & ~ADVERT_WMASK) == 16'h0000;
	endproperty
	a_advert_ro_bits: assert property (p_advert_ro_bits) else $error("read-only advertisement bit set"); // [RQ19]

	property p_np_tx_ro;
		@(posedge clk) disable iff (reset)
		mgmt_req.wr && mgmt_req.addr == OFS_NP_TX && !link_event.codeword_sent
		|=> state_r.np_tx[NP_TX_TOGGLE_BIT] == $past(state_r.np_tx[NP_TX_TOGGLE_BIT]);
	endproperty
	a_np_tx_ro: assert property (p_np_tx_ro) else $error("toggle bit changed by a write"); // [RQ19]

	property p_advert_write;
		@(posedge clk) disable iff (reset)
		mgmt_req.wr && mgmt_req.addr == OFS_ADVERT |=> state_r.advert == ($past(mgmt_req.wdata) & ADVERT_WMASK);
	endproperty
	a_advert_write: assert property (p_advert_write) else $error("advertisement write not taken"); // [RQ2]

	property p_np_tx_write;
		@(posedge clk) disable iff (reset)
		mgmt_req.wr && mgmt_req.addr == OFS_NP_TX
		|=> (state_r.np_tx & NP_TX_WMASK) == ($past(mgmt_req.wdata) & NP_TX_WMASK);
	endproperty
	a_np_tx_write: assert property (p_np_tx_write) else $error("next page transmit write not taken"); // [RQ9]

	property p_gig_write;
		@(posedge clk) disable iff (reset)
		mgmt_req.wr && mgmt_req.addr == OFS_GIG_CTRL |=> state_r.gig_ctrl == $past(mgmt_req.wdata);
	endproperty
	a_gig_write: assert property (p_gig_write) else $error("gigabit control write not taken"); // [RQ12]

	property p_test_mode_out;
		@(posedge clk) disable iff (reset)
		neg_ctrl.test_mode == state_r.gig_ctrl[GIG_TEST_LSB +: 3];
	endproperty
	a_test_mode_out: assert property (p_test_mode_out) else $error("test mode output differs from register"); // [RQ12]

	property p_ms_master_out;
		@(posedge clk) disable iff (reset)
		state_r.gig_ctrl[GIG_MS_MANUAL_BIT] |-> neg_ctrl.ms_master == state_r.gig_ctrl[GIG_MS_VALUE_BIT];
	endproperty
	a_ms_master_out: assert property (p_ms_master_out) else $error("manual master value not applied"); // [RQ15]

	property p_port_type_out;
		@(posedge clk) disable iff (reset)
		neg_ctrl.multi_port == state_r.gig_ctrl[GIG_MULTI_PORT_BIT]
		&& neg_ctrl.adv_1000_full_duplex == state_r.gig_ctrl[GIG_ADV_FULL_DUPLEX_BIT]
		&& neg_ctrl.adv_1000_half_duplex == state_r.gig_ctrl[GIG_ADV_HALF_DUPLEX_BIT];
	endproperty
	a_port_type_out: assert property (p_port_type_out) else $error("gigabit ability outputs differ"); // [RQ16]

	property p_par_fault_clear;
		@(posedge clk) disable iff (reset)
		mgmt_req.rd && mgmt_req.addr == OFS_EXPANSION && !link_event.parallel_fault |=> !state_r.par_fault;
	endproperty
	a_par_fault_clear: assert property (p_par_fault_clear) else $error("parallel fault not cleared by read"); // [RQ5]

	property p_par_fault_hold;
		@(posedge clk) disable iff (reset)
		state_r.par_fault && !(mgmt_req.rd && mgmt_req.addr == OFS_EXPANSION) |=> state_r.par_fault;
	endproperty
	a_par_fault_hold: assert property (p_par_fault_hold) else $error("parallel fault dropped without read"); // [RQ5]

	property p_page_rx_set;
		@(posedge clk) disable iff (reset)
		link_event.base_page_valid || link_event.next_page_valid |=> state_r.page_rx;
	endproperty
	a_page_rx_set: assert property (p_page_rx_set) else $error("page received not latched"); // [RQ6]

	property p_np_rx_capture;
		@(posedge clk) disable iff (reset)
		link_event.next_page_valid |=> state_r.np_rx == $past(link_event.next_page);
	endproperty
	a_np_rx_capture: assert property (p_np_rx_capture) else $error("partner next page not captured"); // [RQ11]

	property p_partner_base_ro;
		@(posedge clk) disable iff (reset)
		!link_event.base_page_valid |=> $stable(state_r.partner_base);
	endproperty
	a_partner_base_ro: assert property (p_partner_base_ro) else $error("partner base page changed"); // [RQ4]

	property p_irq_read_clear;
		@(posedge clk) disable iff (reset)
		mgmt_req.rd && mgmt_req.addr == OFS_IRQ_STATUS |=> state_r.irq_status == $past(irq_events);
	endproperty
	a_irq_read_clear: assert property (p_irq_read_clear) else $error("status read lost an event"); // [RQ18]

	property p_np_sent_return;
		@(posedge clk) disable iff (reset)
		state_r.np_state == NP_SENT |=> state_r.np_state == NP_IDLE;
	endproperty
	a_np_sent_return: assert property (p_np_sent_return) else $error("codeword state stuck"); // [RQ10]

	property p_pending_clear;
		@(posedge clk) disable iff (reset)
		link_event.codeword_sent |=> !neg_ctrl.np_tx_pending;
	endproperty
	a_pending_clear: assert property (p_pending_clear) else $error("pending page not cleared"); // [RQ10]

	property p_np_rx_read;
		@(posedge clk) disable iff (reset)
		mgmt_req.rd && mgmt_req.addr == OFS_NP_RX |=> rdata == $past(state_r.np_rx);
	endproperty
	a_np_rx_read: assert property (p_np_rx_read) else $error("partner next page read wrong"); // [RQ11]

	property p_partner_read;
		@(posedge clk) disable iff (reset)
		mgmt_req.rd && mgmt_req.addr == OFS_PARTNER_BASE |=> rdata == $past(state_r.partner_base);
	endproperty
	a_partner_read: assert property (p_partner_read) else $error("partner base page read wrong"); // [RQ4]

endmodule

// *** pkg/an_regs_pkg.sv ***
// package: offsets, field positions, reset values and carrier types for the negotiation register bank
package an_regs_pkg;

	localparam logic [4:0] OFS_ADVERT = 5'h04;
	localparam logic [4:0] OFS_PARTNER_BASE = 5'h05;
	localparam logic [4:0] OFS_EXPANSION = 5'h06;
	localparam logic [4:0] OFS_NP_TX = 5'h07;
	localparam logic [4:0] OFS_NP_RX = 5'h08;
	localparam logic [4:0] OFS_GIG_CTRL = 5'h09;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h19;

	// writable bits and reset values per register
	localparam logic [15:0] ADVERT_WMASK = 16'hBFFF;
	localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;
	localparam logic [15:0] GIG_CTRL_WMASK = 16'hFFFF;
	localparam logic [15:0] ADVERT_RESET = 16'h01E1;
	localparam logic [15:0] NP_TX_RESET = 16'h2001;
	localparam logic [15:0] GIG_CTRL_RESET = 16'h0700;

	localparam int ADV_NEXT_PAGE_BIT = 15;
	localparam int ADV_REMOTE_FAULT_BIT = 13;
	localparam int ADV_ASYM_PAUSE_BIT = 11;
	localparam int ADV_SYM_PAUSE_BIT = 10;
	localparam int EXP_PAR_FAULT_BIT = 4;
	localparam int EXP_PARTNER_NP_BIT = 3;
	localparam int EXP_LOCAL_NP_BIT = 2;
	localparam int EXP_PAGE_RX_BIT = 1;
	localparam int EXP_PARTNER_AN_BIT = 0;
	localparam int NP_TX_TOGGLE_BIT = 11;
	localparam int GIG_MS_MANUAL_BIT = 12;
	localparam int GIG_MS_VALUE_BIT = 11;
	localparam int GIG_TEST_LSB = 13;
	localparam int GIG_MULTI_PORT_BIT = 10;
	localparam int GIG_ADV_FULL_DUPLEX_BIT = 9;
	localparam int GIG_ADV_HALF_DUPLEX_BIT = 8;

	// interrupt status layout
	localparam int IRQ_PAGE_RX_BIT = 0;
	localparam int IRQ_PAR_FAULT_BIT = 1;
	localparam int IRQ_BASE_PAGE_BIT = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	typedef enum logic [2:0] {
		TEST_NORMAL = 3'h0,
		TEST_WAVEFORM = 3'h1,
		TEST_JITTER_MASTER = 3'h2,
		TEST_JITTER_SLAVE = 3'h3,
		TEST_DISTORTION = 3'h4
	} test_mode_type;

	typedef enum {
		NP_IDLE,
		NP_SENT
	} np_state_type;

	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} mgmt_req_type;

	typedef struct packed {
		logic base_page_valid;
		logic [15:0] base_page;
		logic next_page_valid;
		logic [15:0] next_page;
		logic parallel_fault;
		logic partner_np_able;
		logic partner_an_able;
		logic codeword_sent;
		logic codeword_toggle;
	} link_event_type;

	typedef struct packed {
		test_mode_type test_mode;
		logic ms_manual;
		logic ms_master;
		logic multi_port;
		logic adv_1000_full_duplex;
		logic adv_1000_half_duplex;
		logic next_page_request;
		logic [15:0] advert;
		logic [15:0] np_tx;
		logic np_tx_pending;
	} neg_ctrl_type;

endpackage

// *** sim/far_partner_model.sv ***
// far-side model: pages, faults and codeword events of the remote port
`timescale 1ns/10ps
module far_partner_model
	import an_regs_pkg::*;
(
	input wire logic clk,
	output link_event_type link_event
);
	link_event_type lv = '0;
	initial link_event = '0;
	task automatic pulse(input link_event_type ev);
		@(posedge clk);
		link_event <= ev | lv;
		@(posedge clk);
		link_event <= lv;
	endtask
	task automatic set_able(input logic np, input logic an);
		@(posedge clk);
		lv.partner_np_able = np;
		lv.partner_an_able = an;
		link_event <= lv;
	endtask
	task automatic send_page(input logic nxt, input logic [15:0] p);
		link_event_type ev;
		ev = '0;
		ev.base_page_valid = !nxt;
		ev.next_page_valid = nxt;
		ev.base_page = p;
		ev.next_page = p;
		pulse(ev);
	endtask
	task automatic send_fault();
		link_event_type ev;
		ev = '0;
		ev.parallel_fault = 1'b1;
		pulse(ev);
	endtask
	task automatic sent_cw(input logic t);
		link_event_type ev;
		ev = '0;
		ev.codeword_sent = 1'b1;
		ev.codeword_toggle = t;
		pulse(ev);
	endtask
endmodule

// *** sim/autoneg_gigabit_ctrl_regs_tb_top.sv ***
// self-checking bench for the negotiation register bank
`timescale 1ns/10ps
module autoneg_gigabit_ctrl_regs_tb_top
	import an_regs_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	mgmt_req_type mgmt_req = '0;
	logic [15:0] rdata;
	link_event_type link_event;
	neg_ctrl_type neg_ctrl;
	logic irq;
	logic [15:0] v;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;

	always #50 clk = ~clk;

	autoneg_gigabit_ctrl_regs u_autoneg_gigabit_ctrl_regs (.clk(clk), .reset(reset), .mgmt_req(mgmt_req),
		.rdata(rdata), .link_event(link_event), .neg_ctrl(neg_ctrl), .irq(irq));
	far_partner_model u_far_partner_model (.clk(clk), .link_event(link_event));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		mgmt_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		mgmt_req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		@(posedge clk);
		mgmt_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		mgmt_req.rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] q;
		rd(a, q);
		check(q, e);
	endtask
	task automatic t_reset();
		rdc(5'h04, 16'h01E1);
		rdc(5'h05, 16'h0000);
		rdc(5'h06, 16'h0004);
		rdc(5'h07, 16'h2001);
		rdc(5'h08, 16'h0000);
		rdc(5'h09, 16'h0700);
		check(irq, 1'b0);
		check({neg_ctrl.multi_port, neg_ctrl.adv_1000_full_duplex, neg_ctrl.adv_1000_half_duplex}, 16'h0007);
		check(neg_ctrl.next_page_request, 16'h0000);
		check(neg_ctrl.advert, ADVERT_RESET);
		check(neg_ctrl.np_tx, NP_TX_RESET);
		$display("test reset values done");
	endtask
	task automatic t_access();
		wr(5'h04, 16'hFFFF);
		rdc(5'h04, 16'hBFFF);
		check(neg_ctrl.next_page_request, 16'h0001);
		check(neg_ctrl.advert, 16'hBFFF);
		wr(5'h04, 16'h0000);
		rdc(5'h04, 16'h0000);
		wr(5'h07, 16'hFFFF);
		rdc(5'h07, 16'hB7FF);
		check(neg_ctrl.np_tx, 16'hB7FF);
		check(neg_ctrl.np_tx_pending, 1'b1);
		wr(5'h05, 16'hFFFF);
		wr(5'h06, 16'hFFFF);
		wr(5'h08, 16'hFFFF);
		rdc(5'h05, 16'h0000);
		rdc(5'h06, 16'h0004);
		rdc(5'h08, 16'h0000);
		rdc(5'h1F, 16'h0000);
		// value chosen before manual mode is used
		wr(5'h09, 16'h0800);
		check(neg_ctrl.ms_master, 1'b0);
		wr(5'h09, 16'h1800);
		check({neg_ctrl.ms_manual, neg_ctrl.ms_master}, 2'h3);
		wr(5'h09, 16'h1000);
		check(neg_ctrl.ms_master, 1'b0);
		// media sensing assumed off before non-normal modes
		for (int i = 0; i < 8; i++) begin
			wr(5'h09, {i[2:0], 13'h0700});
			check(neg_ctrl.test_mode, i[2:0]);
			rdc(5'h09, {i[2:0], 13'h0700});
		end
		wr(5'h09, 16'h0000);
		check({neg_ctrl.multi_port, neg_ctrl.adv_1000_full_duplex, neg_ctrl.adv_1000_half_duplex}, 16'h0000);
		rdc(5'h09, 16'h0000);
		wr(5'h09, 16'h0700);
		$display("test access done");
	endtask
	task automatic t_partner();
		u_far_partner_model.send_page(1'b0, 16'hC5E1);
		rdc(5'h05, 16'hC5E1);
		u_far_partner_model.send_page(1'b1, 16'h5A5A);
		rdc(5'h08, 16'h5A5A);
		u_far_partner_model.set_able(1'b1, 1'b1);
		u_far_partner_model.send_fault();
		rdc(5'h06, 16'h001F);
		rdc(5'h06, 16'h000D);
		fork
			u_far_partner_model.send_fault();
			rd(5'h06, v);
		join
		check(v, 16'h000D);
		rdc(5'h06, 16'h001D);
		u_far_partner_model.sent_cw(1'b0);
		rdc(5'h07, 16'hBFFF);
		check(neg_ctrl.np_tx_pending, 1'b0);
		check(neg_ctrl.np_tx, 16'hBFFF);
		u_far_partner_model.sent_cw(1'b1);
		rdc(5'h07, 16'hB7FF);
		$display("test partner done");
	endtask
	task automatic t_irq();
		rd(5'h18, v);
		wr(5'h19, 16'h0002);
		u_far_partner_model.send_page(1'b1, 16'h0001);
		repeat (2) @(posedge clk);
		#1 check(irq, 1'b0);
		u_far_partner_model.send_fault();
		repeat (2) @(posedge clk);
		#1 check(irq, 1'b1);
		rd(5'h18, v);
		check(v, 16'h0003);
		repeat (2) @(posedge clk);
		#1 check(irq, 1'b0);
		rdc(5'h19, 16'h0002);
		wr(5'h19, 16'h0004);
		u_far_partner_model.send_page(1'b0, 16'h4321);
		#1 check(irq, 1'b1);
		rdc(5'h18, 16'h0005);
		rdc(5'h05, 16'h4321);
		$display("test interrupt done");
	endtask
	task automatic t_rerun();
		wr(5'h04, 16'h0000);
		wr(5'h09, 16'h1800);
		u_far_partner_model.send_fault();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rdc(5'h04, 16'h01E1);
		rdc(5'h06, 16'h000D);
		rdc(5'h09, 16'h0700);
		check(neg_ctrl.ms_master, 16'h0000);
		check(irq, 16'h0000);
		$display("test mid-run reset done");
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			$display("ERROR %0t: timeout", $time);
			end_sim();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_access();
		t_partner();
		t_irq();
		t_rerun();
		end_sim();
	end
endmodule
